// ### logic/jtp_pkg.sv
// Package with constants shared by the test access port design.
package jtp_pkg;
  // Instruction and data path widths.
  localparam int IR_W = 4;
  localparam int DR_W = 32;
  localparam int BSC_W = 16;
  localparam int UID_W = 14;
  localparam int UID_LSB = 18;
  localparam int SILREV_W = 18;
  localparam int SEC_W = 16;
  // Security configuration bit positions.
  localparam int SEC_JTAG_OFF = 0;
  localparam int SEC_PLL_OFF = 4;
  // PLL settings register bit positions for device reset and boot select.
  localparam int PLL_RST_BIT = 30;
  localparam int PLL_BOOT_BIT = 29;
  // Consecutive high mode-select cycles that force the reset state.
  localparam logic [2:0] TMS_RST_CNT = 3'h5;
  // Instruction codes.
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_DEVICE_IDENTIFICATION = 4'h1;
  localparam logic [3:0] IR_USERCODE = 4'h2;
  localparam logic [3:0] IR_SAMPLE = 4'h3;
  localparam logic [3:0] IR_CHIPTAP = 4'h4;
  localparam logic [3:0] IR_PLLSET = 4'h8;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  // Capture value of the instruction register.
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  // TAP controller states.
  typedef enum logic [3:0] {
    ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
    ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PA_DR = 4'h6, ST_EX2_DR = 4'h7,
    ST_UP_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'ha, ST_SH_IR = 4'hb,
    ST_EX1_IR = 4'hc, ST_PA_IR = 4'hd, ST_EX2_IR = 4'he, ST_UP_IR = 4'hf
  } jtp_state_t;
endpackage

// ### logic/jtp_fsm.sv
// Standard sixteen-state TAP controller running on the test clock.
`timescale 1ns/100ps
module jtp_fsm (
  // Test clock and mode select.
  input  wire logic               tck,
  input  wire logic               tms,
  // Current controller state.
  output jtp_pkg::jtp_state_t     state
);
  jtp_pkg::jtp_state_t state_reg;
  jtp_pkg::jtp_state_t state_next;
  logic [2:0]          ones_reg;
  logic [2:0]          ones_next;

  // Counts consecutive high mode-select samples, saturating at the reset count.
  assign ones_next = !tms ? 3'h0 : (ones_reg == jtp_pkg::TMS_RST_CNT) ? ones_reg : ones_reg + 3'h1;

  // Next-state decode of the sixteen-state sequence.
  always_comb begin
    case (state_reg)
      jtp_pkg::ST_RESET:  state_next = tms ? jtp_pkg::ST_RESET  : jtp_pkg::ST_IDLE;
      jtp_pkg::ST_IDLE:   state_next = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
      jtp_pkg::ST_SEL_DR: state_next = tms ? jtp_pkg::ST_SEL_IR : jtp_pkg::ST_CAP_DR;
      jtp_pkg::ST_CAP_DR: state_next = tms ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SH_DR;
      jtp_pkg::ST_SH_DR:  state_next = tms ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SH_DR;
      jtp_pkg::ST_EX1_DR: state_next = tms ? jtp_pkg::ST_UP_DR  : jtp_pkg::ST_PA_DR;
      jtp_pkg::ST_PA_DR:  state_next = tms ? jtp_pkg::ST_EX2_DR : jtp_pkg::ST_PA_DR;
      jtp_pkg::ST_EX2_DR: state_next = tms ? jtp_pkg::ST_UP_DR  : jtp_pkg::ST_SH_DR;
      jtp_pkg::ST_UP_DR:  state_next = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
      jtp_pkg::ST_SEL_IR: state_next = tms ? jtp_pkg::ST_RESET  : jtp_pkg::ST_CAP_IR;
      jtp_pkg::ST_CAP_IR: state_next = tms ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SH_IR;
      jtp_pkg::ST_SH_IR:  state_next = tms ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SH_IR;
      jtp_pkg::ST_EX1_IR: state_next = tms ? jtp_pkg::ST_UP_IR  : jtp_pkg::ST_PA_IR;
      jtp_pkg::ST_PA_IR:  state_next = tms ? jtp_pkg::ST_EX2_IR : jtp_pkg::ST_PA_IR;
      jtp_pkg::ST_EX2_IR: state_next = tms ? jtp_pkg::ST_UP_IR  : jtp_pkg::ST_SH_IR;
      jtp_pkg::ST_UP_IR:  state_next = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
      default:            state_next = jtp_pkg::ST_RESET;
    endcase
  end

  // State register; five high samples force the reset state.
  always_ff @(posedge tck) begin
    ones_reg  <= ones_next;
    state_reg <= (ones_next == jtp_pkg::TMS_RST_CNT) ? jtp_pkg::ST_RESET : state_next;
  end

  assign state = state_reg;

  // Five consecutive high samples always land in the reset state.
  a_tms_reset: assert property (@(posedge tck) tms [*5] |=> state_reg == jtp_pkg::ST_RESET)
    else $error("five high tms did not reach reset");
endmodule // jtp_fsm

// ### logic/jtp_sync.sv
// Two-stage synchroniser for a level crossing into a clock domain.
`timescale 1ns/100ps
module jtp_sync #(
  parameter int W = 1
) (
  // Destination clock.
  input  wire logic         clk,
  // Asynchronous level in and synchronised level out.
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // First stage feeds only the second stage.
  always_ff @(posedge clk) begin
    meta_reg <= d;
    sync_reg <= meta_reg;
  end

  assign q = sync_reg;
endmodule // jtp_sync

// ### logic/jtp_tap.sv
// Top of the test access port: instruction and data paths, chip TAP, PLL write.
`timescale 1ns/100ps
module jtp_tap #(
  parameter logic [3:0]  ID_VERSION  = 4'h0,      // Arbitrary value.
  parameter logic [15:0] ID_PART     = 16'h0001,  // Arbitrary value.
  parameter logic [11:0] ID_MAKER    = 12'h0a5,   // Arbitrary value, bit 0 forced to one.
  parameter logic [17:0] SILICON_REV = 18'h00001  // Arbitrary value.
) (
  // System clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Test port pins.
  input  wire logic        tck,
  input  wire logic        tms,
  input  wire logic        tdi,
  output logic             tdo,
  output logic             tdo_oe,
  // Boundary scan of device pins.
  input  wire logic [15:0] pin_in,
  output logic      [15:0] pin_out,
  output logic             pin_test_mode,
  // One-time-programmable words of tile 0.
  input  wire logic [13:0] otp_user_word,
  input  wire logic [15:0] otp_sec_config,
  input  wire logic        otp_user_valid,
  // Chained chip TAP towards the processing tile.
  output logic             chip_tms,
  output logic             chip_tdi,
  output logic             chip_sel,
  input  wire logic        chip_tdo,
  // PLL settings register, system clock side.
  output logic      [31:0] pll_settings,
  output logic             pll_write,
  output logic             dev_reset_req,
  output logic             boot_from_port
);
  jtp_pkg::jtp_state_t state;
  logic [3:0]  ir_sh_reg;
  logic [3:0]  ir_reg;
  logic [31:0] dr_reg;
  logic        byp_reg;
  logic [15:0] bsc_reg;
  logic [15:0] bsc_upd_reg;
  logic        tdo_reg;
  logic        oe_reg;
  logic [31:0] pll_hold_reg;
  logic        pll_tgl_reg;
  logic [31:0] pll_reg;
  logic        pll_wr_reg;
  logic        tgl_seen_reg;
  logic        tgl_sync;
  logic [13:0] uid_sync;
  logic        valid_sync;
  logic [1:0]  sec_sync;
  logic [15:0] pin_sync;
  logic        in_reset;

  // Instruction decode used in several places.
  function automatic logic is_code(input logic [3:0] ir, input logic [3:0] code);
    return ir == code;
  endfunction

  jtp_fsm u_fsm (
    .tck   (tck),
    .tms   (tms),
    .state (state)
  );

  // Inputs from the system domain cross into the test clock domain.
  jtp_sync #(.W(14)) u_uid_sync (.clk(tck), .d(otp_user_word), .q(uid_sync));
  jtp_sync #(.W(1))  u_val_sync (.clk(tck), .d(otp_user_valid), .q(valid_sync));
  jtp_sync #(.W(2))  u_sec_sync (
    .clk (tck),
    .d   ({otp_sec_config[jtp_pkg::SEC_PLL_OFF], otp_sec_config[jtp_pkg::SEC_JTAG_OFF]}),
    .q   (sec_sync)
  );
  // Device pins pass two flip-flops before the boundary cells capture them.
  jtp_sync #(.W(16)) u_pin_sync (.clk(tck), .d(pin_in), .q(pin_sync));
  jtp_sync #(.W(1))  u_tgl_sync (.clk(ref_clk), .d(pll_tgl_reg), .q(tgl_sync));

  // Named decodes of the selected data register.
  wire sel_id    = is_code(ir_reg, jtp_pkg::IR_DEVICE_IDENTIFICATION);
  wire sel_user  = is_code(ir_reg, jtp_pkg::IR_USERCODE);
  wire sel_pll   = is_code(ir_reg, jtp_pkg::IR_PLLSET);
  wire sel_bsc   = is_code(ir_reg, jtp_pkg::IR_EXTEST) | is_code(ir_reg, jtp_pkg::IR_SAMPLE);
  wire sel_chip  = is_code(ir_reg, jtp_pkg::IR_CHIPTAP) & ~sec_sync[0];
  wire sel_byp   = ~(sel_id | sel_user | sel_pll | sel_bsc | sel_chip);
  wire pll_allow = sel_pll & ~sec_sync[1];
  assign in_reset = state == jtp_pkg::ST_RESET;

  // Identification word: version, part number, maker, one.
  wire [31:0] id_word = {ID_VERSION, ID_PART, ID_MAKER[11:1], 1'b1};
  // User identifier reads as zero until boot firmware marks it valid.
  wire [13:0] uid_val = valid_sync ? uid_sync : 14'h0000;
  wire [31:0] user_word = {uid_val, SILICON_REV};

  // Capture value of the data register.
  wire [31:0] dr_cap = sel_id ? id_word : sel_user ? user_word : sel_pll ? pll_hold_reg :
                       sel_bsc ? {16'h0000, pin_sync} : 32'h00000000;
  // Serial output of the selected path.
  wire dr_out = sel_byp ? byp_reg : sel_chip ? chip_tdo : sel_bsc ? bsc_reg[0] : dr_reg[0];
  wire shifting_ir = state == jtp_pkg::ST_SH_IR;
  wire shifting_dr = state == jtp_pkg::ST_SH_DR;

  // Instruction register path.
  always_ff @(posedge tck) begin
    if (in_reset) begin
      ir_sh_reg <= jtp_pkg::IR_CAPTURE;
      ir_reg    <= jtp_pkg::IR_DEVICE_IDENTIFICATION;
    end else begin
      if (state == jtp_pkg::ST_CAP_IR) ir_sh_reg <= jtp_pkg::IR_CAPTURE;
      if (shifting_ir) ir_sh_reg <= {tdi, ir_sh_reg[3:1]};
      if (state == jtp_pkg::ST_UP_IR) ir_reg <= ir_sh_reg;
    end
  end

  // Thirty-two-bit data path, bypass bit and boundary scan cells.
  always_ff @(posedge tck) begin
    if (state == jtp_pkg::ST_CAP_DR) begin
      dr_reg  <= dr_cap;
      byp_reg <= 1'b0;
      bsc_reg <= pin_sync;
    end else if (shifting_dr) begin
      dr_reg  <= {tdi, dr_reg[31:1]};
      byp_reg <= tdi;
      bsc_reg <= {tdi, bsc_reg[15:1]};
    end
    if (in_reset) bsc_upd_reg <= 16'h0000;
    else if (state == jtp_pkg::ST_UP_DR && sel_bsc) bsc_upd_reg <= bsc_reg;
  end

  // PLL settings are held on the test clock and handed over by a toggle.
  always_ff @(posedge tck) begin
    if (in_reset) begin
      pll_hold_reg <= 32'h00000000;
      pll_tgl_reg  <= 1'b0;
    end else if (state == jtp_pkg::ST_UP_DR && pll_allow) begin
      pll_hold_reg <= dr_reg;
      pll_tgl_reg  <= ~pll_tgl_reg;
    end
  end

  // Output on falling edge; enabled only while shifting.
  always_ff @(negedge tck) begin
    tdo_reg <= shifting_ir ? ir_sh_reg[0] : dr_out;
    oe_reg  <= shifting_ir | shifting_dr;
  end

  // System side captures the settings word once the toggle has settled.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pll_reg      <= 32'h00000000;
      pll_wr_reg   <= 1'b0;
      tgl_seen_reg <= 1'b0;
    end else begin
      tgl_seen_reg <= tgl_sync;
      pll_wr_reg   <= tgl_sync ^ tgl_seen_reg;
      if (tgl_sync ^ tgl_seen_reg) pll_reg <= pll_hold_reg;
    end
  end

  // Chip TAP is chained behind this one and gets the pins when selected.
  assign chip_sel = sel_chip;
  assign chip_tms = sel_chip ? tms : 1'b1;
  assign chip_tdi = tdi;
  assign tdo = tdo_reg;
  assign tdo_oe = oe_reg;
  assign pin_out = bsc_upd_reg;
  assign pin_test_mode = is_code(ir_reg, jtp_pkg::IR_EXTEST);
  assign pll_settings = pll_reg;
  assign pll_write = pll_wr_reg;
  assign dev_reset_req = pll_reg[jtp_pkg::PLL_RST_BIT];
  assign boot_from_port = pll_reg[jtp_pkg::PLL_BOOT_BIT];

  // Capture of identification places the word in the shift register.
  a_id_capture: assert property (@(posedge tck) state == jtp_pkg::ST_CAP_DR && sel_id |=> dr_reg == id_word)
    else $error("identification word not captured");
  // Usercode capture carries the user field at the top.
  a_user_capture: assert property (@(posedge tck) state == jtp_pkg::ST_CAP_DR && sel_user
                                   |=> dr_reg[jtp_pkg::DR_W-1:jtp_pkg::UID_LSB] == $past(uid_val))
    else $error("user field not captured");
  // A usercode capture shows a zero user field while the field is not yet valid.
  a_uid_invalid: assert property (@(posedge tck) state == jtp_pkg::ST_CAP_DR && sel_user && !valid_sync
                                  |=> dr_reg[jtp_pkg::DR_W-1:jtp_pkg::UID_LSB] == 14'h0000)
    else $error("user field shown while invalid");
  // Blocked PLL writes leave the hold register unchanged.
  a_pll_block: assert property (@(posedge tck) disable iff (in_reset) sec_sync[1] |=> $stable(pll_hold_reg))
    else $error("pll written while blocked");
  // Tile access denied when disabled.
  a_tile_deny: assert property (@(posedge tck) sec_sync[0] |-> !chip_sel)
    else $error("chip tap reachable while disabled");
  // Bypass delays data by one shift.
  a_bypass_one: assert property (@(posedge tck) shifting_dr && sel_byp |=> byp_reg == $past(tdi))
    else $error("bypass bit wrong");
  // Instruction update takes the shifted value.
  a_ir_update: assert property (@(posedge tck) state == jtp_pkg::ST_UP_IR |=> ir_reg == $past(ir_sh_reg))
    else $error("instruction not updated");
  // A settings write reaches the system side within a few clocks.
  // The edge test is written on the two flops so an unsettled toggle before the first TAP reset is ignored.
  a_pll_cross: assert property (@(posedge ref_clk) disable iff (rst) tgl_sync ^ tgl_seen_reg |=> pll_write)
    else $error("pll write pulse missing");
  // A settings pulse lasts a single system clock.
  a_pll_once: assert property (@(posedge ref_clk) disable iff (rst) pll_write |=> !pll_write)
    else $error("pll write pulse too long");
  // The pulse comes with the word that was shifted in, reset and boot bits included.
  a_pll_land: assert property (@(posedge ref_clk) disable iff (rst) pll_write |-> pll_settings == pll_hold_reg)
    else $error("pll settings differ from shifted word");
  // The serial output is enabled in both shift states.
  a_oe_shift: assert property (@(posedge tck) shifting_ir || shifting_dr |-> tdo_oe)
    else $error("tdo not enabled while shifting");
  // The serial output is released outside the shift states.
  a_oe_idle: assert property (@(posedge tck) !(shifting_ir || shifting_dr) |-> !tdo_oe)
    else $error("tdo enabled outside shift");
  // The reset state selects the identification register.
  a_reset_ir: assert property (@(posedge tck) in_reset |=> ir_reg == jtp_pkg::IR_DEVICE_IDENTIFICATION)
    else $error("reset did not select identification");
  // A boundary update moves the shifted cells to the pins.
  a_bsc_update: assert property (@(posedge tck) state == jtp_pkg::ST_UP_DR && sel_bsc |=> pin_out == $past(bsc_reg))
    else $error("boundary update missing");
endmodule // jtp_tap

// ### tb/jtp_host.sv
// Behavioural test-port host that makes the test clock and shifts frames.
`timescale 1ns/100ps
module jtp_host (
  // Test port pins seen from the host.
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  // The test clock stands low between frames.
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One 48 ns test clock; tdo is taken just before the rising edge.
  task automatic clk(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #24;
    q = tdo;
    tck = 1'b1;
    #24;
    tck = 1'b0;
  endtask
  // Five high mode-select clocks, then step into idle.
  task automatic reset_tap();
    logic q;
    repeat (5) clk(1'b1, ~tdi, q);
    clk(1'b0, ~tdi, q);
  endtask
  // Idle clocks; tdi toggles so a stale level is never seen.
  task automatic idle(input int n);
    logic q;
    repeat (n) clk(1'b0, ~tdi, q);
  endtask
  // Extra clocks so a settings write crosses to the system clock side.
  task automatic pll_tail();
    idle(100);
  endtask
  // Shift n bits, LSB first, through the instruction or data path.
  task automatic shift(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic q;
    dout = 32'h0;
    clk(1'b1, ~tdi, q);
    if (ir) clk(1'b1, ~tdi, q);
    clk(1'b0, ~tdi, q);
    clk(1'b0, ~tdi, q);
    for (int i = 0; i < n; i++) begin
      clk(i == n - 1, din[i], q);
      dout[i] = q;
    end
    clk(1'b1, ~tdi, q);
    clk(1'b0, ~tdi, q);
  endtask
endmodule // jtp_host

// ### tb/jtp_tap_tb_top.sv
// Self-checking testbench for the test access port top.
`timescale 1ns/100ps
module jtp_tap_tb_top;
  // Arbitrary identity values; the maker code has bit 0 clear on purpose.
  localparam logic [3:0]  VER   = 4'h3;
  localparam logic [15:0] PART  = 16'h0123;
  localparam logic [11:0] MAKER = 12'h0a4;
  localparam logic [17:0] SREV  = 18'h00042;
  logic        ref_clk, rst, tck, tms, tdi, tdo, tdo_oe, pin_test_mode;
  logic        otp_user_valid, chip_tms, chip_tdi, chip_sel, chip_tdo;
  logic        pll_write, dev_reset_req, boot_from_port, q;
  logic [15:0] pin_in, pin_out, otp_sec_config;
  logic [13:0] otp_user_word, w;
  logic [31:0] pll_settings, d, r;
  int          n_mismatch, n_compared, n_wr, n_oe, cyc, seed, k;
  jtp_tap #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER), .SILICON_REV(SREV)) dut (
    .ref_clk(ref_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .pin_in(pin_in), .pin_out(pin_out), .pin_test_mode(pin_test_mode), .otp_user_word(otp_user_word),
    .otp_sec_config(otp_sec_config), .otp_user_valid(otp_user_valid), .chip_tms(chip_tms),
    .chip_tdi(chip_tdi), .chip_sel(chip_sel), .chip_tdo(chip_tdo), .pll_settings(pll_settings),
    .pll_write(pll_write), .dev_reset_req(dev_reset_req), .boot_from_port(boot_from_port));
  jtp_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  // System clock at 125 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Chained chip TAP model: a one-bit path from its data input to its output.
  always @(posedge tck) chip_tdo <= chip_tdi;
  // Shift cycles with the serial output enabled are counted.
  always @(posedge tck) if (tdo_oe === 1'b1) n_oe <= n_oe + 1;
  // New settings pulses are counted, hangs are cut.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (pll_write === 1'b1) n_wr <= n_wr + 1;
    if (cyc == 30000) begin
      n_mismatch = n_mismatch + 1;
      end_sim();
    end
  end
  // Compares one result with the model value.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Changes the memory words and lets them cross into the test clock domain.
  task automatic set_otp(input logic [13:0] uw, input logic v, input logic [15:0] s);
    @(negedge ref_clk);
    otp_user_word = uw;
    otp_user_valid = v;
    otp_sec_config = s;
    host.idle(4);
  endtask
  // Main sequence.
  initial begin
    rst = 1'b1;
    {n_mismatch, n_compared, n_wr, n_oe, cyc} = '0;
    seed = 63686;
    {pin_in, otp_user_word, otp_sec_config, otp_user_valid, chip_tdo} = '0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    chk(pll_settings, 32'h0);
    host.reset_tap();
    repeat (12) host.clk(1'($random(seed)), ~tdi, q);
    host.reset_tap();
    k = n_oe;
    host.shift(1'b0, 32, 32'h0, d);
    chk(d, {VER, PART, MAKER[11:1], 1'b1});
    chk(32'(n_oe - k), 32'h20);
    chk(32'(tdo_oe), 32'h0);
    host.shift(1'b1, 4, 32'(jtp_pkg::IR_USERCODE), d);
    chk({28'h0, d[3:0]}, {28'h0, jtp_pkg::IR_CAPTURE});
    for (int i = 0; i < 3; i++) begin
      w = (i == 2) ? 14'h0 : 14'($random(seed));
      set_otp(w, i != 0, 16'h0);
      host.shift(1'b0, 32, 32'h0, d);
      chk(d, {(i == 0) ? 14'h0 : w, SREV});
    end
    for (int c = 5; c < 16; c++) begin
      r = $random(seed);
      if (c != 8) host.shift(1'b1, 4, 32'(c), d);
      if (c != 8) host.shift(1'b0, 32, r, d);
      if (c != 8) chk(d, {r[30:0], 1'b0});
    end
    host.shift(1'b1, 4, 32'(jtp_pkg::IR_CHIPTAP), d);
    chk(32'(chip_sel), 32'h1);
    chk({30'h0, chip_tms, chip_tdi}, {30'h0, tms, tdi});
    r = $random(seed);
    host.shift(1'b0, 32, r, d);
    chk({d[31:1], 1'b0}, {r[30:0], 1'b0});
    set_otp(w, 1'b1, 16'h0001);
    host.shift(1'b1, 4, 32'(jtp_pkg::IR_CHIPTAP), d);
    chk(32'(chip_sel), 32'h0);
    chk({30'h0, chip_tms, chip_tdi}, {30'h0, 1'b1, tdi});
    host.shift(1'b0, 32, r, d);
    chk(d, {r[30:0], 1'b0});
    @(negedge ref_clk);
    pin_in = 16'($random(seed));
    host.shift(1'b1, 4, 32'(jtp_pkg::IR_SAMPLE), d);
    chk(32'(pin_test_mode), 32'h0);
    host.shift(1'b0, 16, r, d);
    chk(d, {16'h0, pin_in});
    chk({16'h0, pin_out}, {16'h0, r[15:0]});
    host.shift(1'b1, 4, 32'(jtp_pkg::IR_EXTEST), d);
    chk(32'(pin_test_mode), 32'h1);
    set_otp(w, 1'b1, 16'h0);
    host.shift(1'b1, 4, 32'(jtp_pkg::IR_PLLSET), d);
    k = n_wr;
    host.shift(1'b0, 32, r, d);
    host.pll_tail();
    chk(pll_settings, r);
    chk({30'h0, dev_reset_req, boot_from_port}, {30'h0, r[30], r[29]});
    chk(32'(n_wr - k), 32'h1);
    set_otp(w, 1'b1, 16'h0010);
    host.shift(1'b1, 4, 32'(jtp_pkg::IR_PLLSET), d);
    host.shift(1'b0, 32, ~r, d);
    chk(d, r);
    host.pll_tail();
    chk(pll_settings, r);
    chk(32'(n_wr - k), 32'h1);
    @(negedge ref_clk);
    rst = 1'b1;
    @(negedge ref_clk);
    rst = 1'b0;
    chk(pll_settings, 32'h0);
    chk({29'h0, pll_write, dev_reset_req, boot_from_port}, 32'h0);
    end_sim();
  end
endmodule // jtp_tap_tb_top
